// >>> common/andc_pkg.sv
package andc_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CORR = 6'h0A;
  localparam logic [5:0] OFF_ANT  = 6'h0D;

  localparam logic [7:0] CORR_RESET   = 8'h07;
  localparam logic [3:0] THRESH_RESET = 4'h7;
  localparam logic [3:0] CORR_UP_RST  = 4'h0;
  localparam logic       DIV_RESET    = 1'b0;
  localparam logic       SWEN_RESET   = 1'b0;
  localparam logic       FLAG_RESET   = 1'b0;
  localparam logic [1:0] CHOICE_RESET = 2'h3;

  localparam int FLAG_BIT  = 7;
  localparam int DIV_BIT   = 3;
  localparam int SWEN_BIT  = 2;
  localparam int CHOICE_HI = 1;
  localparam int CHOICE_LO = 0;
  localparam int THRESH_HI = 3;

  localparam logic [1:0] CHOICE_ANT1 = 2'h1;
  localparam logic [1:0] CHOICE_ANT0 = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 10;
  localparam int DWELL_NS  = 4000;
  localparam int DWELL_CYC = (DWELL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] DWELL_LAST = 9'(DWELL_CYC - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP, ST_IDLE_OFF, ST_SYNTH_ON, ST_RX_LISTEN, ST_RX_BUSY, ST_TX_BUSY
  } andc_trx_t;

  typedef struct packed {
    andc_trx_t state;
    logic      preamble_hit;
    logic      frame_done;
  } andc_rx_ev_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } andc_req_t;

  typedef struct packed {
    logic switch_line_a;
    logic switch_line_b;
    logic oe;
  } andc_pins_t;

endpackage

// >>> design/andc_search.sv
module andc_search import andc_pkg::*; (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Control and receiver events
  input  wire logic run,
  input  wire logic preamble_hit,
  input  wire logic frame_done,
  // Search result
  output logic      ant_q,
  output logic      locked,
  output logic      lock_pulse_q
);

  typedef enum logic {SRCH, LOCK} andc_srch_t;

  andc_srch_t state_q;
  logic [8:0] cnt_q;
  logic       tick;

  assign tick   = run && (state_q == SRCH) && (cnt_q == DWELL_LAST);
  assign locked = (state_q == LOCK);

  // Dwell divider, restarts on every hop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 9'h000;
    end else if (!run || state_q != SRCH || tick) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= SRCH;
    end else if (!run) begin
      state_q <= SRCH; // RL5
    end else begin
      case (state_q)
        SRCH: if (preamble_hit) state_q <= LOCK; // RL2
        LOCK: if (frame_done) state_q <= SRCH; // RL3
        default: state_q <= SRCH;
      endcase
    end
  end

  // A hit in the same cycle as a hop keeps the antenna that saw it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ant_q <= 1'b0;
    end else if (tick && !preamble_hit) begin
      ant_q <= ~ant_q; // RL2
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lock_pulse_q <= 1'b0;
    end else begin
      lock_pulse_q <= run && (state_q == SRCH) && preamble_hit;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_search_hop: assert property (tick && !preamble_hit |=> ant_q != $past(ant_q)) // RL2
    else $error("search did not hop antenna");
  chk_lock_hold: assert property (locked && run && !frame_done |=> locked && $stable(ant_q)) // RL2
    else $error("locked antenna not held");
  chk_frame_resume: assert property (locked && frame_done |=> !locked) // RL3
    else $error("search not resumed after frame");
  chk_run_gate: assert property (!run |=> !locked && $stable(ant_q) ##0 !lock_pulse_q) // RL1
    else $error("search active while disabled");

endmodule

// >>> design/andc_top.sv
// Behaviour
// RL1 - Autonomous two-antenna search runs only while diversity enable is set.
// RL2 - Search locks on antenna seeing a preamble, else alternates antennas.
// RL3 - After a frame completes, search resumes on both antennas alternately.
// RL4 - Chosen-antenna flag holds last frame's value, updates on new lock.
// RL5 - Auto choice kept until new search, leaving receive, or static write.
// RL6 - Transmission uses the static antenna choice field.
// RL7 - With diversity disabled, antenna comes only from static choice field.
// RL8 - Static value 1 selects antenna 1: line A low, line B high.
// RL9 - Static value 2 selects antenna 0: line A high, B low; 3 default.
// RL10 - Static change reaches pins only in synth-on, receive and transmit states.
// RL11 - Switch drive enable drives complementary line pair in every state.
// RL12 - Switch drive disabled holds both lines low.
// RL13 - Flag reads 0 for antenna 0, 1 for antenna 1.
// RL14 - Software sets switch drive enable together with diversity enable.
// RL15 - On disabling switch drive, software clears diversity and writes 3.
// RL16 - Software sets threshold 3 with diversity, 7 otherwise.
// RL17 - Software never enables switch drive and frame stamp pin together.
// RL18 - Software should disable switch drive outside receive and transmit.
// RL19 - Software reads chosen-antenna flag after frame-start interrupt.
// RL20 - Search runs autonomously in basic and extended modes.
// RL21 - Reserved antenna register bits read zero and ignore writes.
module andc_top import andc_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Register port
  input  wire andc_req_t   req,
  output logic [7:0]       reg_rdata_q,
  // Receiver state and events
  input  wire andc_rx_ev_t rx_ev,
  // Receiver correlator setting
  output logic [3:0]       correlator_threshold_q,
  // External RF switch lines
  output andc_pins_t       pins_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] corr_up_q;
  logic       div_en_q;
  logic       sw_en_q;
  logic [1:0] choice_q;
  logic [1:0] applied_q;
  logic       override_q;
  logic       chosen_q;
  logic       eng_ant;
  logic       eng_locked;
  logic       lock_pulse;
  logic       rx_state;
  logic       active_state;
  logic       eng_run;
  logic       auto_sel;
  logic       static_bit;
  logic       sel_ant;
  logic       wr_corr;
  logic       wr_ant;
  logic       choice_change;
  logic [7:0] rd_d;
  andc_pins_t pins_d;

  assign rx_state     = (rx_ev.state == ST_RX_LISTEN) || (rx_ev.state == ST_RX_BUSY);
  assign active_state = rx_state || (rx_ev.state == ST_SYNTH_ON)
                        || (rx_ev.state == ST_TX_BUSY);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    wr_corr = 1'b0;
    wr_ant  = 1'b0;
    if (req.wr && req.addr == OFF_CORR) begin
      wr_corr = 1'b1;
    end else if (req.wr && req.addr == OFF_ANT) begin
      wr_ant = 1'b1;
    end
  end

  assign choice_change = wr_ant && (req.wdata[CHOICE_HI:CHOICE_LO] != choice_q);

  // Threshold is software's to manage; no automatic retune
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      correlator_threshold_q <= THRESH_RESET;
      corr_up_q              <= CORR_UP_RST;
    end else if (wr_corr) begin
      correlator_threshold_q <= req.wdata[THRESH_HI:0];
      corr_up_q              <= req.wdata[7:4];
    end
  end

  // Flag bit and reserved bits are not stored from writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_en_q <= DIV_RESET;
      sw_en_q  <= SWEN_RESET;
      choice_q <= CHOICE_RESET;
    end else if (wr_ant) begin
      div_en_q <= req.wdata[DIV_BIT];
      sw_en_q  <= req.wdata[SWEN_BIT];
      choice_q <= req.wdata[CHOICE_HI:CHOICE_LO]; // RL21
    end
  end

  // ----------------------------------------------------------------
  // Static choice as seen by the pins
  // ----------------------------------------------------------------
  // Writes while idle are parked until the synthesizer is up
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      applied_q <= CHOICE_RESET;
    end else if (active_state) begin
      applied_q <= choice_q; // RL10
    end
  end

  // Only 1 means antenna 1; 2, and the reserved or default codes, mean antenna 0
  always_comb begin
    static_bit = 1'b0;
    if (applied_q == CHOICE_ANT1) begin
      static_bit = 1'b1; // RL8
    end else if (applied_q == CHOICE_ANT0) begin
      static_bit = 1'b0; // RL9
    end
  end

  // ----------------------------------------------------------------
  // Manual override of a locked antenna
  // ----------------------------------------------------------------
  // Set wins over the lock that would release it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      override_q <= 1'b0;
    end else if (choice_change) begin
      override_q <= 1'b1; // RL5
    end else if (lock_pulse || !rx_state) begin
      override_q <= 1'b0; // RL5
    end
  end

  // ----------------------------------------------------------------
  // Search engine
  // ----------------------------------------------------------------
  // Needs no host traffic once enabled
  assign eng_run = div_en_q && rx_state; // RL1 RL20

  andc_search u_search (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .run          (eng_run),
    .preamble_hit (rx_ev.preamble_hit),
    .frame_done   (rx_ev.frame_done),
    .ant_q        (eng_ant),
    .locked       (eng_locked),
    .lock_pulse_q (lock_pulse)
  );

  // ----------------------------------------------------------------
  // Antenna selection and pin drive
  // ----------------------------------------------------------------
  // Transmit and idle states fall back to the static field
  assign auto_sel = div_en_q && rx_state && !override_q; // RL6 RL7
  assign sel_ant  = auto_sel ? eng_ant : static_bit;

  always_comb begin
    pins_d.oe            = sw_en_q; // RL11
    pins_d.switch_line_a = sw_en_q && !sel_ant; // RL11
    pins_d.switch_line_b = sw_en_q && sel_ant; // RL11
  end

  // Disabled lines are parked low, standing in for the pull-downs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d; // RL12
    end
  end

  // ----------------------------------------------------------------
  // Chosen-antenna flag
  // ----------------------------------------------------------------
  // Frame end does not clear it; with diversity on only a fresh lock moves it, with it off it follows the static choice
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chosen_q <= FLAG_RESET;
    end else if (!div_en_q) begin
      chosen_q <= static_bit; // RL13
    end else if (lock_pulse) begin
      chosen_q <= eng_ant; // RL4
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    if (req.addr == OFF_CORR) begin
      rd_d = {corr_up_q, correlator_threshold_q};
    end else if (req.addr == OFF_ANT) begin
      rd_d = {chosen_q, 3'h0, div_en_q, sw_en_q, choice_q}; // RL21
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (req.rd) begin
      reg_rdata_q <= rd_d;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_drive_pair: assert property (sw_en_q |=> pins_q.oe && (pins_q.switch_line_a != pins_q.switch_line_b)) // RL11
    else $error("switch lines not complementary");
  chk_lines_low: assert property (!sw_en_q |=> !pins_q.oe && !pins_q.switch_line_a && !pins_q.switch_line_b) // RL12
    else $error("switch lines not low while disabled");
  chk_tx_static: assert property (rx_ev.state == ST_TX_BUSY && sw_en_q |=> pins_q.switch_line_b == $past(static_bit)) // RL6
    else $error("transmit not on static antenna");
  chk_static_only: assert property (!div_en_q && sw_en_q |=> pins_q.switch_line_b == $past(static_bit)) // RL7
    else $error("static antenna not used");
  chk_code_one: assert property (!auto_sel && sw_en_q && applied_q == CHOICE_ANT1 |=> !pins_q.switch_line_a && pins_q.switch_line_b) // RL8
    else $error("code 1 drive wrong");
  chk_code_two: assert property (!auto_sel && sw_en_q && applied_q == CHOICE_ANT0 |=> pins_q.switch_line_a && !pins_q.switch_line_b) // RL9
    else $error("code 2 drive wrong");
  chk_idle_park: assert property (!active_state |=> $stable(applied_q)) // RL10
    else $error("static change applied while idle");
  chk_flag_hold: assert property (div_en_q && !lock_pulse |=> $stable(chosen_q)) // RL4
    else $error("flag moved without a lock");
  chk_flag_lock: assert property (div_en_q && lock_pulse |=> chosen_q == $past(eng_ant)) // RL4
    else $error("flag not updated on lock");
  chk_flag_static: assert property (!div_en_q |=> chosen_q == $past(static_bit)) // RL13
    else $error("flag does not follow static choice");
  chk_auto_drive: assert property (auto_sel && sw_en_q |=> pins_q.switch_line_b == $past(eng_ant)) // RL2
    else $error("pins not on searched antenna");
  chk_override_rel: assert property (choice_change && rx_state |=> !auto_sel) // RL5
    else $error("static write did not release lock");
  chk_engine_gate: assert property (!div_en_q |-> !eng_run ##1 !lock_pulse) // RL1
    else $error("search runs with diversity off");
  chk_resv_zero: assert property (req.rd && req.addr == OFF_ANT |=> reg_rdata_q[6:4] == 3'h0) // RL21
    else $error("reserved bits not zero");

  cov_lock: cover property (eng_run ##1 lock_pulse ##1 eng_locked);
  cov_resume: cover property (eng_locked && rx_ev.frame_done ##1 !eng_locked);
  cov_tx_static: cover property (sw_en_q && div_en_q && rx_ev.state == ST_TX_BUSY);
  cov_override: cover property (eng_locked && choice_change);

endmodule

// >>> verification/andc_rf_switch.sv
module andc_rf_switch import andc_pkg::*; (
  // Switch control from the device
  input  wire andc_pins_t pins,
  // Observed switch position
  output logic            line_a,
  output logic            line_b,
  output logic            ant
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Pull-downs win when the device lets go, never the last value
  assign line_a = pins.oe ? pins.switch_line_a : 1'b0;
  // Line B is never shared with frame stamping in this bench
  assign line_b = pins.oe ? pins.switch_line_b : 1'b0;
  // Only the pair A low, B high routes antenna 1
  assign ant    = line_b & ~line_a;
endmodule

// >>> verification/andc_test.sv
module andc_test import andc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); end end

  logic        clk_sys;
  logic        rstn;
  andc_req_t   req;
  logic [7:0]  reg_rdata_q;
  andc_rx_ev_t rx_ev;
  logic [3:0]  thr;
  andc_pins_t  pins_q;
  logic        line_a;
  logic        line_b;
  logic        ant;
  logic [7:0]  d;
  logic        a_lock;
  int          c;
  int          fail_count;
  int          n_checks;

  andc_top andc_top_i (
    .clk_sys                (clk_sys),
    .rstn                   (rstn),
    .req                    (req),
    .reg_rdata_q            (reg_rdata_q),
    .rx_ev                  (rx_ev),
    .correlator_threshold_q (thr),
    .pins_q                 (pins_q)
  );

  andc_rf_switch andc_rf_switch_i (
    .pins   (pins_q),
    .line_a (line_a),
    .line_b (line_b),
    .ant    (ant)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Strobe is dropped before the next call, so no step drives req twice
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    #1;
    v = reg_rdata_q;
    req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic wait_hop(input int lim, input bit must, output int n);
    logic a0;
    a0 = ant;
    n = 0;
    while (ant === a0 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (must && n == lim) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic pulse(input bit hit);
    if (hit) rx_ev.preamble_hit <= 1'b1;
    else rx_ev.frame_done <= 1'b1;
    @(posedge clk_sys);
    rx_ev.preamble_hit <= 1'b0;
    rx_ev.frame_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #900000;
    fail_count++;
    stop_test();
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    req = '0;
    rx_ev = '{state: ST_IDLE_OFF, preamble_hit: 1'b0, frame_done: 1'b0};
    rstn = 1'b0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_ANT, d);
    `CHK(d, 8'h03)
    rd(OFF_CORR, d);
    `CHK(d, 8'h07)
    `CHK(thr, 4'h7)
    `CHK(pins_q, 3'h0)
    wr(6'h3F, 8'hFF);
    rd(6'h3F, d);
    `CHK(d, 8'h00)
    wr(OFF_ANT, 8'h75);
    rd(OFF_ANT, d);
    `CHK(d, 8'h05)
    $display("test reset done");

    rx_ev.state <= ST_SYNTH_ON;
    for (int k = 0; k < 4; k++) begin
      wr(OFF_ANT, 8'h04 | 8'(k));
      repeat (3) @(posedge clk_sys);
      `CHK(pins_q, (k == 1) ? 3'h3 : 3'h5)
      rd(OFF_ANT, d);
      `CHK(d, ((k == 1) ? 8'h84 : 8'h04) | 8'(k))
    end
    rx_ev.state <= ST_IDLE_OFF;
    wr(OFF_ANT, 8'h05);
    repeat (3) @(posedge clk_sys);
    `CHK(pins_q, 3'h5)
    rx_ev.state <= ST_SYNTH_ON;
    repeat (3) @(posedge clk_sys);
    `CHK(pins_q, 3'h3)
    wr(OFF_ANT, 8'h03);
    repeat (2) @(posedge clk_sys);
    `CHK({pins_q, line_a, line_b}, 5'h00)
    $display("test static done");

    wr(OFF_CORR, 8'hF3);
    rd(OFF_CORR, d);
    `CHK(d, 8'hF3)
    `CHK(thr, 4'h3)
    wr(OFF_ANT, 8'h0E);
    rx_ev.state <= ST_RX_LISTEN;
    wait_hop(DWELL_CYC + 20, 1'b1, c);
    wait_hop(DWELL_CYC + 20, 1'b1, c);
    `CHK(c, DWELL_CYC)
    a_lock = ant;
    pulse(1'b1);
    wait_hop(2 * DWELL_CYC, 1'b0, c);
    `CHK(c, 2 * DWELL_CYC)
    rd(OFF_ANT, d);
    `CHK(d, {a_lock, 7'h0E})
    pulse(1'b0);
    wait_hop(DWELL_CYC + 20, 1'b1, c);
    rd(OFF_ANT, d);
    `CHK(d[7], a_lock)
    $display("test diversity done");

    a_lock = ant;
    pulse(1'b1);
    wr(OFF_ANT, a_lock ? 8'h0F : 8'h0D);
    repeat (3) @(posedge clk_sys);
    `CHK(ant, ~a_lock)
    rx_ev.state <= ST_TX_BUSY;
    repeat (3) @(posedge clk_sys);
    `CHK(ant, ~a_lock)
    wr(OFF_ANT, 8'h06);
    rx_ev.state <= ST_RX_LISTEN;
    // Also lets the new static antenna settle before the hop watch
    wr(OFF_CORR, 8'hF7);
    `CHK(thr, 4'h7)
    wait_hop(2 * DWELL_CYC, 1'b0, c);
    `CHK(c, 2 * DWELL_CYC)
    `CHK(pins_q, 3'h5)
    $display("test override done");
    stop_test();
  end
endmodule
